/* File: smr_pkg.sv */
// Package for the supply monitor, reset and clock control block.
// Assumes a 20 MHz aclk and a 32-bit AXI4-Lite register bus.
package smr_pkg;
  // Clock rate and timing
  localparam int CLK_HZ = 20000000;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = (SETTLE_US * CLK_HZ) / 1000000;
  localparam int HALT_WAKE_MS = 1;
  localparam int HALT_WAKE_CYC_DEF = (HALT_WAKE_MS * CLK_HZ) / 1000;
  localparam int RESET_SEQ_CYC_DEF = 64;
  localparam int IDLE_WAKE_CYC_DEF = 8192;
  // Register byte offsets
  localparam logic [3:0] ADDR_SUPPLY_CTRL = 4'h0;
  localparam logic [3:0] ADDR_HALT_CTRL = 4'h4;
  localparam logic [3:0] ADDR_CFG_STAT = 4'h8;
  // Supply detect control fields
  localparam int FLAG_BIT = 0;
  localparam int SRC_BIT = 2;
  localparam int LVL_LSB = 3;
  localparam int LVL_MSB = 7;
  // Halt control fields
  localparam int HALT_BIT = 0;
  localparam int IDLE_BIT = 1;
  // Clock source codes
  localparam logic [1:0] CLK_INT = 2'h0;
  localparam logic [1:0] CLK_SQUARE = 2'h1;
  localparam logic [1:0] CLK_XTAL = 2'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SMR_HOLD, SMR_SEQ, SMR_RUN, SMR_HALT, SMR_WAKE, SMR_IDLE
  } smr_state_t;
endpackage

/* File: smr_top.sv */
// Supply supervision, reset sourcing, clock select and low-power control.
// Assumes comparator and reset-source inputs are asynchronous levels,
// and that configuration bits arrive from a programming-mode interface.
// What this block does
// RL1: Hold reset while brownout low; start reset sequence once it clears.
// RL2: Release core to fetch first instruction when reset sequence ends.
// RL3: Brownout acts only with its config bit; software cannot clear it.
// RL4: Clearing brownout config bit needs programming mode, no write protect.
// RL5: Low-supply flag set below threshold, cleared when back above it.
// RL6: Flag at bit 0 is read-only; 1 means below threshold.
// RL7: Bits 7..3 pick one of 32 thresholds, changeable any time.
// RL8: Flag causes no hardware action and no interrupt.
// RL9: Bit 2 routes external monitor pin, else supply, to comparator.
// RL10: Detector config bit set/cleared in programming mode only, guarded.
// RL11: Detector off in halt and idle; software waits 10 us after.
// RL12: Any reset restores registers, pins input; clock after start delay.
// RL13: Power-on, brownout, watchdog and pin resets start the sequence.
// RL14: Internal mode divides oscillator by two; oscillator stops in halt.
// RL15: Two-bit clock select: internal, square, crystal, reserved.
// RL16: Square clock mode uses external clock input undivided.
// RL17: Write 1 to bit 0 enters halt; self-clears on leaving.
// RL18: Halt stops oscillator and monitors; only wakeup logic or a power-on, watchdog or pin reset ends it.
// RL19: After halt wakeup, wait oscillator start-up delay before running.
// RL20: Write bit 1 with bit 0 clear enters idle; self-clears on leaving idle.
// RL21: Idle keeps oscillator, watchdog, timer; overflow every 8192 wakes.
// RL22: Comparator outputs pass two-stage synchronisers before use.
module smr_top
  import smr_pkg::*;
#(
  parameter int RESET_SEQ_CYC = RESET_SEQ_CYC_DEF,
  parameter int HALT_WAKE_CYC = HALT_WAKE_CYC_DEF,
  parameter int IDLE_WAKE_CYC = IDLE_WAKE_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic brownout_cmp_low,
  input wire logic supply_cmp_low,
  input wire logic ext_cmp_low,
  input wire logic por_req,
  input wire logic watchdog_req,
  input wire logic ext_reset_n,
  input wire logic multi_input_wakeup,
  input wire logic program_mode,
  input wire logic global_write_protect,
  input wire logic cfg_wr,
  input wire logic cfg_brownout_en,
  input wire logic cfg_monitor_en,
  input wire logic [1:0] cfg_clock_sel,
  input wire logic ext_clock_in,
  input wire logic osc_clk,
  output logic core_reset,
  output logic core_clk,
  output logic osc_enable,
  output logic crystal_drive_out,
  output logic detector_enable,
  output logic [4:0] threshold_level_sel,
  output logic monitor_source_sel,
  output logic brownout_reset,
  output logic pins_to_input,
  output logic low_power
);
  smr_state_t state_reg;
  logic [31:0] cnt_reg;
  logic brownout_enable_cfg, supply_monitor_enable_cfg;
  logic [1:0] clock_source_sel;
  logic bo_s1, bo_s2, sup_s1, sup_s2, ext_s1, ext_s2;
  logic low_supply_flag, osc_div_reg, osc_prev_reg;
  logic halt_enable, idle_enable;
  logic aw_hold, w_hold;
  logic [3:0] awaddr_reg;
  logic [7:0] wbyte_reg;
  logic reset_src, wr_fire;

  // Non-volatile config: only programming mode writes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brownout_enable_cfg <= 1'b0;
      supply_monitor_enable_cfg <= 1'b0;
      clock_source_sel <= CLK_INT;
    end else if (cfg_wr && program_mode) begin
      // Sets always pass; clears blocked by write protect
      if (cfg_brownout_en || !global_write_protect) // RL3 RL4
        brownout_enable_cfg <= cfg_brownout_en;
      if (cfg_monitor_en || !global_write_protect) // RL10
        supply_monitor_enable_cfg <= cfg_monitor_en;
      if (cfg_clock_sel != 2'h3) // RL15
        clock_source_sel <= cfg_clock_sel;
    end
  end

  // Two-stage synchronisers; first stage read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_s1 <= 1'b0;
      bo_s2 <= 1'b0;
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      bo_s1 <= brownout_cmp_low; // RL22
      bo_s2 <= bo_s1;
      sup_s1 <= supply_cmp_low;
      sup_s2 <= sup_s1;
      ext_s1 <= ext_cmp_low;
      ext_s2 <= ext_s1;
    end
  end

  // Brownout only counts while enabled and not stopped by halt or idle
  assign brownout_reset = brownout_enable_cfg && bo_s2 &&
                          (state_reg != SMR_HALT) &&
                          (state_reg != SMR_IDLE); // RL3 RL18
  assign reset_src = por_req || brownout_reset || watchdog_req ||
                     !ext_reset_n; // RL13

  // Detector runs only outside halt and idle
  assign detector_enable = supply_monitor_enable_cfg &&
                           (state_reg != SMR_HALT) &&
                           (state_reg != SMR_IDLE); // RL11 RL18
  assign osc_enable = (state_reg != SMR_HALT) &&
                      (clock_source_sel == CLK_INT); // RL14 RL18

  // Flag follows the comparator level; no interrupt path exists
  always_ff @(posedge aclk) begin
    if (!aresetn)
      low_supply_flag <= 1'b0;
    else if (!detector_enable)
      low_supply_flag <= 1'b0;
    else
      low_supply_flag <= monitor_source_sel ? ext_s2 : sup_s2; // RL5 RL9 RL8
  end

  // Power state machine and its single shared counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SMR_HOLD;
      cnt_reg <= 32'h0;
    end else if (reset_src) begin
      state_reg <= SMR_HOLD; // RL1 RL13
      cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        SMR_HOLD: begin
          state_reg <= SMR_SEQ; // RL1
          cnt_reg <= 32'h0;
        end
        SMR_SEQ: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg >= 32'(RESET_SEQ_CYC - 1))
            state_reg <= SMR_RUN; // RL2 RL12
        end
        SMR_RUN: begin
          cnt_reg <= 32'h0;
          if (wr_fire && awaddr_reg == ADDR_HALT_CTRL) begin
            if (wbyte_reg[HALT_BIT])
              state_reg <= SMR_HALT; // RL17
            else if (wbyte_reg[IDLE_BIT])
              state_reg <= SMR_IDLE; // RL20
          end
        end
        SMR_HALT: begin
          cnt_reg <= 32'h0;
          if (multi_input_wakeup)
            state_reg <= SMR_WAKE; // RL18
        end
        SMR_WAKE: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg >= 32'(HALT_WAKE_CYC - 1))
            state_reg <= SMR_RUN; // RL19
        end
        SMR_IDLE: begin
          // Timer overflow period stands in for timer 0
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg >= 32'(IDLE_WAKE_CYC - 1))
            state_reg <= SMR_RUN; // RL21
        end
        default: state_reg <= SMR_HOLD;
      endcase
    end
  end

  assign core_reset = (state_reg == SMR_HOLD) || (state_reg == SMR_SEQ);
  assign pins_to_input = core_reset; // RL12
  assign low_power = (state_reg == SMR_HALT) || (state_reg == SMR_IDLE) ||
                     (state_reg == SMR_WAKE);
  // Write-only bits read back as live mode, clearing on exit
  assign halt_enable = (state_reg == SMR_HALT); // RL17
  assign idle_enable = (state_reg == SMR_IDLE); // RL20

  // Divide-by-two on rising edges of the sampled oscillator level;
  // a level test alone would toggle on every aclk of a slow high phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev_reg <= 1'b0;
      osc_div_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_clk;
      if (osc_clk && !osc_prev_reg && osc_enable)
        osc_div_reg <= ~osc_div_reg; // RL14
    end
  end

  // Core clock mux; stopped in reset, halt and the wake settling delay
  always_comb begin
    core_clk = 1'b0;
    if (!core_reset && state_reg != SMR_HALT &&
        state_reg != SMR_WAKE) begin // RL12 RL19
      case (clock_source_sel)
        CLK_INT: core_clk = osc_div_reg; // RL14
        CLK_SQUARE: core_clk = ext_clock_in; // RL16
        CLK_XTAL: core_clk = ext_clock_in;
        default: core_clk = 1'b0;
      endcase
    end
  end
  assign crystal_drive_out = (clock_source_sel == CLK_XTAL) &&
                             (state_reg != SMR_HALT) && !ext_clock_in;

  // AXI write: take address and data in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      awaddr_reg <= 4'h0;
      wbyte_reg <= 8'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        wbyte_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h0;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg == ADDR_SUPPLY_CTRL ||
                        awaddr_reg == ADDR_HALT_CTRL ||
                        awaddr_reg == ADDR_CFG_STAT) ? RESP_OKAY
                                                     : RESP_SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control fields; flag bit ignored on write
  always_ff @(posedge aclk) begin
    if (!aresetn || core_reset) begin
      threshold_level_sel <= 5'h0; // RL12
      monitor_source_sel <= 1'b0;
    end else if (wr_fire && awaddr_reg == ADDR_SUPPLY_CTRL) begin
      threshold_level_sel <= wbyte_reg[LVL_MSB:LVL_LSB]; // RL7
      monitor_source_sel <= wbyte_reg[SRC_BIT]; // RL9 RL6
    end
  end

  // AXI read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_SUPPLY_CTRL: s_axi_rdata <= {24'h0, threshold_level_sel,
                            monitor_source_sel, 1'b0, low_supply_flag}; // RL6
        ADDR_HALT_CTRL: s_axi_rdata <= {30'h0, idle_enable, halt_enable};
        ADDR_CFG_STAT: s_axi_rdata <= {24'h0, supply_monitor_enable_cfg,
                          brownout_enable_cfg, clock_source_sel, 1'b0,
                          state_reg};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Assertions
  a_brownout_holds: assert property ( // RL1
    @(posedge aclk) disable iff (!aresetn)
    brownout_reset |=> core_reset)
    else $error("brownout did not hold reset");
  a_seq_length: assert property ( // RL2
    @(posedge aclk) disable iff (!aresetn)
    $fell(reset_src) |-> core_reset [*2])
    else $error("reset sequence too short");
  a_bo_needs_cfg: assert property ( // RL3
    @(posedge aclk) disable iff (!aresetn)
    !brownout_enable_cfg |-> !brownout_reset)
    else $error("brownout active while disabled");
  a_cfg_protect: assert property ( // RL4
    @(posedge aclk) disable iff (!aresetn)
    (!program_mode || global_write_protect) && brownout_enable_cfg
    |=> brownout_enable_cfg)
    else $error("brownout config cleared while protected");
  a_flag_follow: assert property ( // RL5
    @(posedge aclk) disable iff (!aresetn)
    detector_enable && !monitor_source_sel && sup_s2 &&
    $stable(detector_enable)
    |=> low_supply_flag || !detector_enable || monitor_source_sel)
    else $error("flag not set when low");
  a_halt_stops: assert property ( // RL18
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_HALT |-> !osc_enable && !detector_enable)
    else $error("halt left systems running");
  a_idle_detect: assert property ( // RL11
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_IDLE |-> !detector_enable && !brownout_reset)
    else $error("detector running in idle");
  a_halt_entry: assert property ( // RL17
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_RUN && !reset_src && wr_fire &&
    awaddr_reg == ADDR_HALT_CTRL && wbyte_reg[HALT_BIT]
    |=> halt_enable)
    else $error("halt not entered");
  a_wake_delay: assert property ( // RL19
    @(posedge aclk) disable iff (!aresetn)
    $rose(state_reg == SMR_WAKE) |-> !(state_reg == SMR_RUN) [*2])
    else $error("halt wake skipped delay");
  a_square_clk: assert property ( // RL16
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_RUN && clock_source_sel == CLK_SQUARE
    |-> core_clk == ext_clock_in)
    else $error("square clock not passed");
  a_monitor_protect: assert property ( // RL10
    @(posedge aclk) disable iff (!aresetn)
    (!program_mode || global_write_protect) && supply_monitor_enable_cfg
    |=> supply_monitor_enable_cfg)
    else $error("detector config cleared while protected");
  // Only wakeup or a reset source may end halt
  a_halt_exit: assert property ( // RL18
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_HALT && !multi_input_wakeup && !reset_src
    |=> state_reg == SMR_HALT)
    else $error("halt left without wakeup");
  a_reg_restore: assert property ( // RL12
    @(posedge aclk) disable iff (!aresetn)
    core_reset |=> threshold_level_sel == 5'h0 && !monitor_source_sel)
    else $error("control fields not restored by reset");
  // A low flag alone never moves the power state
  a_run_steady: assert property ( // RL8
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_RUN && !reset_src && !wr_fire
    |=> state_reg == SMR_RUN)
    else $error("run state left without cause");
  a_wake_clk_off: assert property ( // RL19
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_WAKE |-> !core_clk)
    else $error("core clock ran during wake delay");
  a_flag_off: assert property ( // RL11
    @(posedge aclk) disable iff (!aresetn)
    !detector_enable |=> !low_supply_flag)
    else $error("flag set while detector off");
  a_seq_release: assert property ( // RL2
    @(posedge aclk) disable iff (!aresetn)
    state_reg == SMR_SEQ && !reset_src &&
    cnt_reg >= 32'(RESET_SEQ_CYC - 1) |=> !core_reset)
    else $error("core not released after sequence");
  a_xtal_drive: assert property ( // RL15
    @(posedge aclk) disable iff (!aresetn)
    clock_source_sel != CLK_XTAL |-> !crystal_drive_out)
    else $error("crystal drive active outside crystal mode");
endmodule

/* File: test_smr_top.sv */
// Self-checking bench for the supply monitor, reset and clock block.
// Assumes smr_pkg and smr_top are compiled first; bench drives all pins.
module test_smr_top
  import smr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, brownout_cmp_low;
  logic supply_cmp_low, ext_cmp_low, por_req, watchdog_req, ext_reset_n;
  logic multi_input_wakeup, program_mode, global_write_protect, cfg_wr;
  logic cfg_brownout_en, cfg_monitor_en, ext_clock_in, osc_clk, core_reset;
  logic core_clk, osc_enable, crystal_drive_out, detector_enable;
  logic monitor_source_sel, brownout_reset, pins_to_input, low_power;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, cfg_clock_sel, rsp;
  logic [4:0] threshold_level_sel;
  int n_mismatch = 0;
  int compares = 0;

  // Short counts keep the halt and idle waits cheap
  smr_top #(.RESET_SEQ_CYC(4), .HALT_WAKE_CYC(8), .IDLE_WAKE_CYC(16)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .brownout_cmp_low, .supply_cmp_low, .ext_cmp_low,
    .por_req, .watchdog_req, .ext_reset_n, .multi_input_wakeup,
    .program_mode, .global_write_protect, .cfg_wr, .cfg_brownout_en,
    .cfg_monitor_en, .cfg_clock_sel, .ext_clock_in, .osc_clk, .core_reset,
    .core_clk, .osc_enable, .crystal_drive_out, .detector_enable,
    .threshold_level_sel, .monitor_source_sel, .brownout_reset,
    .pins_to_input, .low_power);

  // Clock and a slower oscillator stand-in
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) osc_clk <= ~osc_clk;

  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Poll the status state field, bounded
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 60; i++) begin
      rd(ADDR_CFG_STAT);
      if (rv[2:0] === s) break;
    end
    chk("state", rv[2:0], s);
  endtask

  task automatic cfg(input logic pm, b, m, input logic [1:0] c);
    program_mode <= pm;
    cfg_brownout_en <= b;
    cfg_monitor_en <= m;
    cfg_clock_sel <= c;
    cfg_wr <= 1'b1;
    @(posedge aclk);
    cfg_wr <= 1'b0;
    program_mode <= 1'b0;
    @(posedge aclk);
    rd(ADDR_CFG_STAT);
  endtask

  task automatic t_reset();
    chk("hold", core_reset, 1'b1);
    chk("pins_in", pins_to_input, 1'b1);
    wait_st(SMR_RUN);
    chk("run", core_reset, 1'b0);
    rd(ADDR_SUPPLY_CTRL);
    chk("sup_rst", rv, 32'h0);
    rd(4'hC);
    chk("rd_unmap", rsp, RESP_SLVERR);
    wr(4'hC, 32'h0);
    chk("wr_unmap", rsp, RESP_SLVERR);
  endtask

  task automatic t_cfg();
    int n;
    logic prev;
    cfg(1'b0, 1'b1, 1'b1, 2'h0);
    chk("cfg_nopm", rv[7:6], 2'h0);
    cfg(1'b1, 1'b1, 1'b1, 2'h0);
    chk("cfg_set", rv[7:6], 2'h3);
    global_write_protect <= 1'b1;
    cfg(1'b1, 1'b0, 1'b0, 2'h0);
    chk("cfg_wp", rv[7:6], 2'h3);
    global_write_protect <= 1'b0;
    cfg(1'b1, 1'b0, 1'b1, 2'h0);
    chk("cfg_clr", rv[7:6], 2'h2);
    brownout_cmp_low <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("bo_off", core_reset, 1'b0);
    brownout_cmp_low <= 1'b0;
    // Let the synchroniser drain before brownout is enabled again
    repeat (3) @(posedge aclk);
    for (int c = 0; c < 4; c++) begin
      cfg(1'b1, 1'b1, 1'b1, 2'(c));
      chk("clk_sel", rv[5:4], (c == 3) ? 2'h2 : 2'(c));
      chk("xtal_out", crystal_drive_out, c >= 2);
    end
    // Square mode passes the external level straight through
    cfg(1'b1, 1'b1, 1'b1, CLK_SQUARE);
    ext_clock_in <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("sq_hi", core_clk, 1'b1);
    ext_clock_in <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("sq_lo", core_clk, 1'b0);
    cfg(1'b1, 1'b1, 1'b1, CLK_INT);
    // Oscillator rises every 2 cycles, so core clock changes every 2
    n = 0;
    prev = core_clk;
    repeat (8) begin
      @(posedge aclk);
      if (core_clk !== prev) n++;
      prev = core_clk;
    end
    chk("int_div", n, 4);
  endtask

  task automatic t_flag();
    wr(ADDR_SUPPLY_CTRL, 32'hFD);
    rd(ADDR_SUPPLY_CTRL);
    chk("ctl_rb", rv, 32'hFC);
    chk("lvl", threshold_level_sel, 5'h1F);
    chk("src", monitor_source_sel, 1'b1);
    supply_cmp_low <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(ADDR_SUPPLY_CTRL);
    chk("flag_ext0", rv[0], 1'b0);
    ext_cmp_low <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(ADDR_SUPPLY_CTRL);
    chk("flag_ext1", rv[0], 1'b1);
    chk("no_act", core_reset, 1'b0);
    wr(ADDR_SUPPLY_CTRL, 32'h0);
    rd(ADDR_SUPPLY_CTRL);
    chk("flag_vcc1", rv, 32'h1);
    supply_cmp_low <= 1'b0;
    repeat (5) @(posedge aclk);
    rd(ADDR_SUPPLY_CTRL);
    chk("flag_vcc0", rv, 32'h0);
    ext_cmp_low <= 1'b0;
  endtask

  // Brownout and the other sources each rerun the reset sequence
  task automatic t_sources();
    wr(ADDR_SUPPLY_CTRL, 32'h50);
    brownout_cmp_low <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("bo_rst", brownout_reset, 1'b1);
    rd(ADDR_CFG_STAT);
    chk("bo_hold", rv[2:0], SMR_HOLD);
    brownout_cmp_low <= 1'b0;
    wait_st(SMR_RUN);
    rd(ADDR_SUPPLY_CTRL);
    chk("bo_clr", rv, 32'h0);
    for (int i = 0; i < 3; i++) begin
      por_req <= (i == 0);
      watchdog_req <= (i == 1);
      ext_reset_n <= (i != 2);
      repeat (3) @(posedge aclk);
      chk("src_rst", core_reset, 1'b1);
      por_req <= 1'b0;
      watchdog_req <= 1'b0;
      ext_reset_n <= 1'b1;
      wait_st(SMR_RUN);
    end
  endtask

  task automatic t_power();
    wr(ADDR_HALT_CTRL, 32'h1);
    rd(ADDR_CFG_STAT);
    chk("halt_st", rv[2:0], SMR_HALT);
    chk("osc_off", osc_enable, 1'b0);
    chk("det_off", detector_enable, 1'b0);
    chk("clk_off", core_clk, 1'b0);
    chk("lp_halt", low_power, 1'b1);
    repeat (20) @(posedge aclk);
    rd(ADDR_HALT_CTRL);
    chk("halt_bit", rv[1:0], 2'h1);
    multi_input_wakeup <= 1'b1;
    repeat (2) @(posedge aclk);
    multi_input_wakeup <= 1'b0;
    rd(ADDR_CFG_STAT);
    chk("wake_st", rv[2:0], SMR_WAKE);
    repeat (2) begin
      chk("wake_clk", core_clk, 1'b0);
      @(posedge aclk);
    end
    wait_st(SMR_RUN);
    rd(ADDR_HALT_CTRL);
    chk("halt_clr", rv[1:0], 2'h0);
    wr(ADDR_HALT_CTRL, 32'h2);
    rd(ADDR_CFG_STAT);
    chk("idle_st", rv[2:0], SMR_IDLE);
    chk("osc_idle", osc_enable, 1'b1);
    chk("det_idle", detector_enable, 1'b0);
    wait_st(SMR_RUN);
    rd(ADDR_HALT_CTRL);
    chk("idle_clr", rv[1:0], 2'h0);
    chk("lp_run", low_power, 1'b0);
  endtask

  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: the whole run needs only a few hundred cycles
  initial begin
    #(50 * 20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, brownout_cmp_low, supply_cmp_low} = '0;
    {ext_cmp_low, por_req, watchdog_req, multi_input_wakeup} = '0;
    {program_mode, global_write_protect, cfg_wr, cfg_brownout_en} = '0;
    {cfg_monitor_en, ext_clock_in, osc_clk} = '0;
    ext_reset_n = 1'b1;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    cfg_clock_sel = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_cfg();
    t_flag();
    t_sources();
    t_power();
    final_report();
  end
endmodule
